// File: design/dmpt_regs.svh
// Purpose: Named constants for the demand-mode pattern tester.
// Assumes: Included by the design file only.
// Notes:   Bit positions refer to the control word and descriptor words.
`ifndef DMPT_REGS_SVH
`define DMPT_REGS_SVH

// =============================================================
// Control word layout
`define DMPT_CTRL_RUN      0
`define DMPT_CTRL_FAILED   1
`define DMPT_CTRL_STARTED  2
`define DMPT_CTRL_RSVD     3
`define DMPT_CTRL_RESET    4'h0

// =============================================================
// Descriptor word layout
`define DMPT_DESC_DIR_BIT  63
`define DMPT_DESC_LEN_MSB  31
`define DMPT_DIR_TO_HOST   1'b1
`define DMPT_DIR_TO_CARD   1'b0

// =============================================================
// Pattern and counters
`define DMPT_PAT_SEED      32'h0000_0000
`define DMPT_PAT_STEP      32'h0000_0001
`define DMPT_ADDR_SHIFT    2
`define DMPT_CNT_ZERO      32'h0000_0000
`define DMPT_CNT_ONE       32'h0000_0001

`endif

// File: design/dmpt_pkg.sv
// Purpose: Types shared by the demand-mode pattern tester.
// Assumes: 64-bit qword stream toward and from the DMA engine.
// Notes:   Constants live in dmpt_regs.svh.
package dmpt_pkg;

	// =========================================================
	// Kind of beat sent to the engine
	typedef enum logic [1:0] {
		DMPT_TX_RETADDR,
		DMPT_TX_DESC,
		DMPT_TX_ADDR,
		DMPT_TX_DATA
	} dmpt_tx_kind_e;

	typedef struct packed {
		dmpt_tx_kind_e kind;
		logic          rd_phase;
		logic [63:0]   data;
	} dmpt_tx_s;

	// =========================================================
	// Beat returned from the engine
	typedef struct packed {
		logic        is_desc;
		logic [63:0] data;
	} dmpt_rx_s;

endpackage

// File: design/dmpt_tester.sv
// Purpose: Demand-mode write/read-back pattern tester and its rx FIFO.
// Assumes: One clock, synchronous reset; engine keeps its own rules.
// Notes:   Data dwords travel in the low half of each 64-bit beat.
`include "dmpt_regs.svh"

// =============================================================
// Return-path FIFO
module dmpt_fifo #(
	parameter int WIDTH = 65,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wr_d  = push ? AW'((32'(wr_q) + 1) % DEPTH) : wr_q;
		rd_d  = pop ? AW'((32'(rd_q) + 1) % DEPTH) : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
		if (push)
			mem_q[wr_q] <= in_data;
	end
endmodule

// =============================================================
// Tester
// How it works
// (R1) Stay idle until software sets run-enable, then start a test.
// (R2) Send 64-bit return address as two halves, for write and read.
// (R3) Write phase sends incrementing dwords, transfer-size dwords per descriptor.
// (R4) Control word: bit0 run, bit1 read-failed, bit2 read-started, bit3 reserved.
// (R5) After write data, wait for the write-completion descriptor.
// (R6) Repeat write descriptor plus data until total size is covered.
// (R7) Read request is two qwords: descriptor word then address word.
// (R8) Engine sends read-completion descriptor then data, with no gap.
// (R9) During read data set read-started and check each dword.
// (R10) Any data mismatch sets read-failed.
// (R11) Read descriptors ask as many dwords as write descriptors wrote.
// (R12) Loop reads until total covered, then clear run and go idle.
// (R13) Expected pattern restarts at the write seed for the read phase.
module dmpt_tester #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             run_set,
	input  wire logic [63:0]      ret_addr,
	input  wire logic [63:0]      host_addr,
	input  wire logic [31:0]      total_size,
	input  wire logic [31:0]      xfer_size,
	output      logic [3:0]       ctrl,
	output      logic [3:0]       state_code,
	output      logic             tx_valid,
	input  wire logic             tx_ready,
	output      dmpt_pkg::dmpt_tx_s tx_beat,
	input  wire logic             rx_valid,
	output      logic             rx_ready,
	input  wire dmpt_pkg::dmpt_rx_s rx_beat
);
	import dmpt_pkg::*;

	typedef enum logic [3:0] {
		IDLE, W_RA0, W_RA1, R_RA0, R_RA1, W_DESC, W_ADDR, W_DATA, W_WAIT,
		read_request_header_state, read_request_address_state,
		read_completion_wait_state, read_pattern_check_state, R_WAIT
	} dmpt_state_e;

	dmpt_state_e st_q, st_d;
	logic [3:0]  ctrl_q, ctrl_d;
	logic [31:0] done_q, done_d, beat_q, beat_d, pat_q, pat_d;
	logic        txv_q, txv_d;
	dmpt_tx_s    tx_q, tx_d;
	logic        out_free, emit;
	dmpt_tx_s    emit_beat;
	logic        fq_valid, fq_ready;
	dmpt_rx_s    fq_data;
	logic [63:0] cur_addr, desc_word;
	logic [31:0] done_next;

	// =========================================================
	// Return-path buffer
	dmpt_fifo #(
		.WIDTH ($bits(dmpt_rx_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   (rx_beat),
		.out_valid (fq_valid),
		.out_ready (fq_ready),
		.out_data  (fq_data)
	);

	assign ctrl       = ctrl_q;
	assign state_code = st_q;
	assign tx_valid   = txv_q;
	assign tx_beat    = tx_q;
	assign out_free   = !txv_q || tx_ready;
	assign done_next  = done_q + xfer_size;
	assign cur_addr   = host_addr + {30'h0, done_q, 2'h0};

	// =========================================================
	// Next-state logic
	always_comb begin
		st_d      = st_q;
		ctrl_d    = ctrl_q;
		done_d    = done_q;
		beat_d    = beat_q;
		pat_d     = pat_q;
		emit      = 1'b0;
		emit_beat = '0;
		fq_ready  = 1'b0;
		desc_word = '0;
		desc_word[`DMPT_DESC_LEN_MSB:0] = xfer_size; // see (R11)
		ctrl_d[`DMPT_CTRL_RSVD] = 1'b0; // see (R4)
		case (st_q)
			IDLE: begin
				if (run_set) begin // see (R1)
					ctrl_d = `DMPT_CTRL_RESET;
					ctrl_d[`DMPT_CTRL_RUN] = 1'b1; // see (R4)
					done_d = `DMPT_CNT_ZERO;
					pat_d  = `DMPT_PAT_SEED;
					st_d   = W_RA0;
				end
			end
			W_RA0, W_RA1, R_RA0, R_RA1: begin
				emit = 1'b1; // see (R2)
				emit_beat.kind     = DMPT_TX_RETADDR;
				emit_beat.rd_phase = (st_q == R_RA0) || (st_q == R_RA1);
				emit_beat.data[31:0] = (st_q == W_RA0 || st_q == R_RA0) ?
					ret_addr[31:0] : ret_addr[63:32];
				if (out_free) begin
					case (st_q)
						W_RA0:   st_d = W_RA1;
						W_RA1:   st_d = R_RA0;
						R_RA0:   st_d = R_RA1;
						default: st_d = W_DESC;
					endcase
				end
			end
			W_DESC: begin
				emit = 1'b1;
				emit_beat.kind = DMPT_TX_DESC;
				emit_beat.data = desc_word;
				emit_beat.data[`DMPT_DESC_DIR_BIT] = `DMPT_DIR_TO_HOST;
				if (out_free)
					st_d = W_ADDR;
			end
			W_ADDR: begin
				emit = 1'b1;
				emit_beat.kind = DMPT_TX_ADDR;
				emit_beat.data = cur_addr;
				if (out_free) begin
					beat_d = `DMPT_CNT_ZERO;
					st_d   = W_DATA;
				end
			end
			W_DATA: begin
				emit = 1'b1; // see (R3)
				emit_beat.kind = DMPT_TX_DATA;
				emit_beat.data[31:0] = pat_q;
				if (out_free) begin
					pat_d  = pat_q + `DMPT_PAT_STEP;
					beat_d = beat_q + `DMPT_CNT_ONE;
					if (beat_q + `DMPT_CNT_ONE >= xfer_size)
						st_d = W_WAIT;
				end
			end
			W_WAIT: begin
				fq_ready = 1'b1; // see (R5)
				if (fq_valid && fq_data.is_desc) begin
					done_d = done_next;
					if (done_next < total_size) begin // see (R6)
						st_d = W_DESC;
					end else begin
						done_d = `DMPT_CNT_ZERO;
						pat_d  = `DMPT_PAT_SEED; // see (R13)
						st_d   = read_request_header_state;
					end
				end
			end
			read_request_header_state: begin
				emit = 1'b1; // see (R7)
				emit_beat.kind     = DMPT_TX_DESC;
				emit_beat.rd_phase = 1'b1;
				emit_beat.data     = desc_word; // see (R11)
				emit_beat.data[`DMPT_DESC_DIR_BIT] = `DMPT_DIR_TO_CARD;
				if (out_free)
					st_d = read_request_address_state;
			end
			read_request_address_state: begin
				emit = 1'b1; // see (R7)
				emit_beat.kind     = DMPT_TX_ADDR;
				emit_beat.rd_phase = 1'b1;
				emit_beat.data     = cur_addr;
				if (out_free)
					st_d = read_completion_wait_state;
			end
			read_completion_wait_state: begin
				fq_ready = 1'b1;
				if (fq_valid && fq_data.is_desc) begin // see (R8)
					beat_d = `DMPT_CNT_ZERO;
					st_d   = read_pattern_check_state;
				end
			end
			read_pattern_check_state: begin
				fq_ready = 1'b1;
				ctrl_d[`DMPT_CTRL_STARTED] = 1'b1; // see (R9)
				if (fq_valid) begin
					if (fq_data.is_desc || fq_data.data[31:0] != pat_q)
						ctrl_d[`DMPT_CTRL_FAILED] = 1'b1; // see (R10)
					pat_d  = pat_q + `DMPT_PAT_STEP;
					beat_d = beat_q + `DMPT_CNT_ONE;
					if (beat_q + `DMPT_CNT_ONE >= xfer_size)
						st_d = R_WAIT;
				end
			end
			R_WAIT: begin
				done_d = done_next;
				if (done_next < total_size) begin // see (R12)
					st_d = read_request_header_state;
				end else begin
					ctrl_d[`DMPT_CTRL_RUN] = 1'b0; // see (R12)
					st_d = IDLE;
				end
			end
			default: st_d = IDLE;
		endcase
		txv_d = emit ? 1'b1 : (tx_ready ? 1'b0 : txv_q);
		tx_d  = (emit && out_free) ? emit_beat : tx_q;
	end

	// =========================================================
	// State registers
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q   <= IDLE;
			ctrl_q <= `DMPT_CTRL_RESET;
			done_q <= `DMPT_CNT_ZERO;
			beat_q <= `DMPT_CNT_ZERO;
			pat_q  <= `DMPT_PAT_SEED;
			txv_q  <= 1'b0;
			tx_q   <= '0;
		end else begin
			st_q   <= st_d;
			ctrl_q <= ctrl_d;
			done_q <= done_d;
			beat_q <= beat_d;
			pat_q  <= pat_d;
			txv_q  <= txv_d;
			tx_q   <= tx_d;
		end
	end
endmodule

// File: verif/dmpt_checker.sv
// Purpose: Port-level checks on the pattern tester.
// Assumes: One clock, srst synchronous active high.
// Notes:   Bound into dmpt_tester below.
// =====
// Checker
module dmpt_checker (
	input wire logic               clk,
	input wire logic               srst,
	input wire logic               run_set,
	input wire logic [63:0]        ret_addr,
	input wire logic [31:0]        xfer_size,
	input wire logic [3:0]         ctrl,
	input wire logic [3:0]         state_code,
	input wire logic               tx_valid,
	input wire logic               tx_ready,
	input wire dmpt_pkg::dmpt_tx_s tx_beat
);
	import dmpt_pkg::*;
	logic hi_q;
	logic hi_d;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Tracks which half of the return address is due next
	always_comb hi_d = (tx_valid && tx_ready &&
		tx_beat.kind == DMPT_TX_RETADDR) ? !hi_q : hi_q;
	always_ff @(posedge clk) hi_q <= srst ? 1'b0 : hi_d;
	a_idle_hold: assert property (
		state_code == 4'h0 && !run_set |=> state_code == 4'h0)
		else $error("left idle");
	a_ret_half: assert property (
		tx_valid && tx_beat.kind == DMPT_TX_RETADDR |-> tx_beat.data[31:0]
		== (hi_q ? ret_addr[63:32] : ret_addr[31:0])) else $error("half");
	a_desc_len: assert property (
		tx_valid && tx_beat.kind == DMPT_TX_DESC |-> tx_beat.data[31:0]
		== xfer_size && tx_beat.data[63] == !tx_beat.rd_phase)
		else $error("desc");
	a_desc_addr: assert property (
		tx_valid && tx_ready && tx_beat.kind == DMPT_TX_DESC |=>
		tx_valid && tx_beat.kind == DMPT_TX_ADDR) else $error("addr");
	a_rsvd_zero: assert property (ctrl[3] == 1'b0)
		else $error("reserved");
	a_write_wait: assert property (
		state_code == 4'h8 |-> !tx_valid || tx_beat.kind == DMPT_TX_DATA)
		else $error("sent in wait");
	a_started_set: assert property (
		state_code == 4'hc |=> ctrl[2]) else $error("started");
	a_fail_src: assert property (
		$rose(ctrl[1]) |-> $past(state_code) == 4'hc) else $error("failed");
	a_read_loop: assert property (
		state_code == 4'hd |=> state_code == 4'h9 ||
		(state_code == 4'h0 && !ctrl[0])) else $error("loop");
	c_run: cover property (state_code == 4'h0 && run_set);
	c_fail: cover property ($rose(ctrl[1]));
	c_loop: cover property (state_code == 4'hd ##1 state_code == 4'h9);
endmodule

bind dmpt_tester dmpt_checker chk_i (.clk(clk), .srst(srst),
	.run_set(run_set), .ret_addr(ret_addr), .xfer_size(xfer_size),
	.ctrl(ctrl), .state_code(state_code), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_beat(tx_beat));

// File: verif/dmpt_engine_model.sv
// Purpose: Behavioural DMA engine facing the tester.
// Assumes: Completion is one descriptor beat.
// Notes:   bad flips bit 0 of the first dword of each read; junk floods stray beats.
// =====
// Engine model
module dmpt_engine_model (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               slow,
	input  wire logic               bad,
	input  wire logic               junk,
	input  wire logic [31:0]        xfer,
	input  wire logic               tx_valid,
	output      logic               tx_ready,
	input  wire dmpt_pkg::dmpt_tx_s tx_beat,
	output      logic               rx_valid,
	input  wire logic               rx_ready,
	output      dmpt_pkg::dmpt_rx_s rx_beat
);
	import dmpt_pkg::*;
	logic [31:0] mem[$];
	dmpt_rx_s    q[$];
	int          n;
	int          rd;
	initial begin
		{tx_ready, rx_valid, rx_beat} = '0;
	end
	always @(posedge clk) begin
		if (srst) begin
			mem = {};
			q = {};
			n = 0;
			rd = 0;
		end else begin
			if (rx_valid && rx_ready)
				void'(q.pop_front());
			if (tx_valid && tx_ready) begin
				if (tx_beat.kind == DMPT_TX_DATA) begin
					mem.push_back(tx_beat.data[31:0]);
					n++;
					if (n == xfer) begin
						n = 0;
						q.push_back('{1'b1, 64'h0});
					end
				end
				if (tx_beat.kind == DMPT_TX_DESC && junk && !tx_beat.rd_phase)
					repeat (20) q.push_back('{1'b0, 64'h0});
				if (tx_beat.kind == DMPT_TX_ADDR && tx_beat.rd_phase) begin
					q.push_back('{1'b1, 64'h0});
					for (int i = 0; i < xfer; i++)
						q.push_back('{1'b0,
							{32'h0, mem[rd + i] ^ {31'h0, bad && i == 0}}});
					rd = rd + int'(xfer);
				end
			end
		end
		// Idle data lines toggle so stale values are never trusted
		rx_valid <= !srst && q.size() > 0;
		rx_beat <= q.size() > 0 ? q[0] : ~rx_beat;
		tx_ready <= !slow || !tx_ready;
	end
endmodule

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the pattern tester.
// Assumes: Engine model answers every request it takes.
// Notes:   Inputs change on the falling edge.
// =====
// Bench
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import dmpt_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        run_set = 1'b0;
	logic [63:0] ret_addr = 64'h0123_4567_89ab_cdef;
	logic [63:0] host_addr = 64'h0000_0001_0000_0000;
	logic [31:0] total_size = 32'h4;
	logic [31:0] xfer_size = 32'h4;
	logic [31:0] pat;
	logic [3:0]  ctrl;
	logic [3:0]  state_code;
	logic        tx_valid, tx_ready, rx_valid, rx_ready, full_seen;
	logic        slow = 1'b0, bad = 1'b0, junk = 1'b0;
	dmpt_tx_s    tx_beat;
	dmpt_rx_s    rx_beat;
	int          err_count = 0, samples_checked = 0, ndata, nrd, nwa, nra;
	always #4 clk = ~clk;
	dmpt_tester dut (.clk(clk), .srst(srst), .run_set(run_set),
		.ret_addr(ret_addr), .host_addr(host_addr),
		.total_size(total_size), .xfer_size(xfer_size), .ctrl(ctrl),
		.state_code(state_code), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_beat(tx_beat), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_beat(rx_beat));
	dmpt_engine_model eng (.clk(clk), .srst(srst), .slow(slow), .bad(bad),
		.junk(junk), .xfer(xfer_size), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_beat(tx_beat), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_beat(rx_beat));
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		if (!rx_ready)
			full_seen <= 1'b1;
		if (tx_valid && tx_ready && tx_beat.kind == DMPT_TX_DATA) begin
			chk("data", tx_beat.data[31:0], pat);
			pat <= pat + 32'h1;
			ndata <= ndata + 1;
		end
		if (tx_valid && tx_ready && tx_beat.kind == DMPT_TX_DESC)
			nrd <= nrd + int'(tx_beat.rd_phase);
		if (tx_valid && tx_ready && tx_beat.kind == DMPT_TX_ADDR) begin
			chk("addr lo", tx_beat.data[31:0], host_addr[31:0] +
				(xfer_size << 2) * (tx_beat.rd_phase ? nra : nwa));
			chk("addr hi", tx_beat.data[63:32], host_addr[63:32]);
			if (tx_beat.rd_phase)
				nra <= nra + 1;
			else
				nwa <= nwa + 1;
		end
	end
	task automatic start(input logic [31:0] t, x, input logic s, b, j);
		srst = 1'b1;
		{total_size, xfer_size, slow, bad, junk} = {t, x, s, b, j};
		repeat (3) @(negedge clk);
		srst = 1'b0;
		{pat, full_seen} = '0;
		ndata = 0;
		nrd = 0;
		nwa = 0;
		nra = 0;
	endtask
	task automatic run(input logic [31:0] t, x, input logic s, b, j);
		int k;
		start(t, x, s, b, j);
		run_set = 1'b1;
		@(negedge clk);
		run_set = 1'b0;
		@(negedge clk);
		for (k = 0; k < 4000 && state_code !== 4'h0; k++)
			@(negedge clk);
		if (k == 4000) begin
			err_count++;
			complete_run();
		end
		k = (t + x - 1) / x;
		chk("ctrl", ctrl, {2'b01, b, 1'b0});
		chk("data beats", ndata, k * x);
		chk("reads", nrd, k);
		chk("fifo full", full_seen, j);
	endtask
	task automatic s_idle;
		start(32'h4, 32'h4, 1'b0, 1'b0, 1'b0);
		repeat (12) @(negedge clk);
		chk("state", state_code, 4'h0);
		chk("tx_valid", tx_valid, 1'b0);
	endtask
	task automatic s_basic;
		run(32'h8, 32'h4, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic s_partial;
		run(32'h5, 32'h2, 1'b1, 1'b0, 1'b0);
	endtask
	task automatic s_fail;
		run(32'h1, 32'h1, 1'b0, 1'b1, 1'b0);
	endtask
	task automatic s_flood;
		run(32'h10, 32'h10, 1'b1, 1'b0, 1'b1);
	endtask
	initial begin
		s_idle();
		s_basic();
		s_partial();
		s_fail();
		s_flood();
		complete_run();
	end
endmodule
